// ===== shared/acc_pkg.sv
/*
  Package for the analog comparator control block: register offsets,
  bit positions, reset values, mode encodings and timing counts.
  Assumes a plain address/strobe register port with 8-bit data.
*/
package acc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ACC_AW = 4;  // Register address width
  localparam int ACC_DW = 8;  // Register data width

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ACC_AW-1:0] ACC_OFS_CTRL_STATUS = 4'h0; // Main register
  localparam logic [ACC_AW-1:0] ACC_OFS_SPECIAL = 4'h1;     // Mux enable reg
  localparam logic [ACC_AW-1:0] ACC_OFS_CONV_CTRL = 4'h2;   // Converter enable
  localparam logic [ACC_AW-1:0] ACC_OFS_CHAN = 4'h3;        // Channel field

  // ----------------------------------------------------------------
  // Bit positions in the control/status register
  // ----------------------------------------------------------------
  localparam int ACC_BIT_POWER_OFF = 7;
  localparam int ACC_BIT_BANDGAP = 6;
  localparam int ACC_BIT_OUT_STATUS = 5;
  localparam int ACC_BIT_IRQ_FLAG = 4;
  localparam int ACC_BIT_IRQ_EN = 3;
  localparam int ACC_BIT_CAPTURE = 2;
  localparam int ACC_BIT_MODE_HI = 1;
  localparam int ACC_BIT_MODE_LO = 0;

  // Other register bits
  localparam int ACC_BIT_MUX_EN = 3;   // In the special function register
  localparam int ACC_BIT_CONV_EN = 7;  // In the converter control register
  localparam int ACC_CHAN_LSB = 0;     // Channel field low bit
  localparam int ACC_CHAN_W = 3;       // Channel field width

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic ACC_RESET_BIT = 1'b0;         // All control bits
  localparam logic [2:0] ACC_CHAN_RESET = 3'h0;  // Channel field
  localparam int ACC_SYNC_STAGES = 2;            // Output synchronizer depth

  // ----------------------------------------------------------------
  // Interrupt mode encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
  localparam logic [1:0] ACC_MODE_RESERVED = 2'h1;
  localparam logic [1:0] ACC_MODE_FALL = 2'h2;
  localparam logic [1:0] ACC_MODE_RISE = 2'h3;

  // Negative input source select
  typedef enum logic {ACC_NEG_PIN, ACC_NEG_CHANNEL} acc_neg_e;

endpackage : acc_pkg

// ===== design/acc_top.sv
/*
  Analog comparator control: register file, output synchronizer,
  interrupt flag logic, capture routing and input selection.
  Register reads answer one cycle after the strobe.
  Assumes the analog comparator itself, the timer capture front end
  and the processor's vector logic sit outside this module.
  CMP_RAW is sampled by CLK; it need not be glitch free.
*/
// Local design decisions: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Power-off bit switches the comparator off
// - Bandgap bit picks positive input source
// - Output status read through two-flop synchronizer
// - Flag set on event matching mode
// - Flag cleared by vector or one-write
// - Request only with enable and global enable
// - Routing bit connects output to capture
// - Capture path filters routed output like pin
// - Mode 00 toggle, 01 none, 10 fall, 11 rise
// - Mux on, converter off: channel drives negative
// - Otherwise negative input pin drives comparator
// - Mux enable is bit 3, read/write
module acc_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [acc_pkg::ACC_AW-1:0] ADDR,
  input wire logic [acc_pkg::ACC_DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [acc_pkg::ACC_DW-1:0] RDATA,
  // Processor side
  input wire logic GLOBAL_IRQ_EN,
  input wire logic IRQ_ACK,
  output logic IRQ_REQ,
  // Analog comparator control and raw result
  input wire logic CMP_RAW,
  output logic CMP_POWER_OFF,
  output logic CMP_POS_BANDGAP,
  output logic CMP_NEG_FROM_CHANNEL,
  output logic [acc_pkg::ACC_CHAN_W-1:0] CMP_NEG_CHANNEL,
  // Timer capture front end
  output logic CAPTURE_ROUTE_EN,
  output logic CAPTURE_SRC
);
  import acc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic power_off;             // Comparator disabled
    logic bandgap;               // Bandgap on positive input
    logic irq_flag;              // Sticky event flag
    logic irq_en;                // Interrupt enable
    logic capture;               // Route to capture front end
    logic [1:0] mode;            // Interrupt mode
    logic mux_en;                // Negative mux enable
    logic conv_en;               // Converter enable
    logic [ACC_CHAN_W-1:0] chan; // Channel field
    logic [ACC_SYNC_STAGES-1:0] sync; // Synchronizer chain
    logic prev;                  // Last synchronized value
    logic [ACC_DW-1:0] rdata;    // Read data
  } acc_state_s;

  acc_state_s cur; // Registered state
  acc_state_s nxt; // Next state

  logic out_sync; // Synchronized comparator output
  logic event_hit; // Event matching the mode
  logic cs_wr; // Write to control/status
  logic [ACC_DW-1:0] cs_val; // Control/status read view
  logic sf_wr; // Write to special function register
  logic cv_wr; // Write to converter enable copy
  logic ch_wr; // Write to channel field
  logic flag_clr; // Vector or write-one clears the flag

  // Event decode for a given mode
  function automatic logic acc_match(input logic [1:0] mode,
                                     input logic now, input logic old);
    case (mode)
      ACC_MODE_TOGGLE: acc_match = now ^ old;
      ACC_MODE_FALL: acc_match = old & ~now;
      ACC_MODE_RISE: acc_match = now & ~old;
      default: acc_match = 1'b0; // Reserved mode never fires
    endcase
  endfunction : acc_match

  // Address match for one strobe against one register offset
  function automatic logic acc_hit(input logic strobe,
                                   input logic [ACC_AW-1:0] addr,
                                   input logic [ACC_AW-1:0] ofs);
    acc_hit = strobe && (addr == ofs);
  endfunction : acc_hit

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  assign out_sync = cur.sync[ACC_SYNC_STAGES-1];
  assign event_hit = acc_match(cur.mode, out_sync, cur.prev);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // One write strobe per register; unmapped writes hit none
  assign cs_wr = acc_hit(WR, ADDR, ACC_OFS_CTRL_STATUS);
  assign sf_wr = acc_hit(WR, ADDR, ACC_OFS_SPECIAL);
  assign cv_wr = acc_hit(WR, ADDR, ACC_OFS_CONV_CTRL);
  assign ch_wr = acc_hit(WR, ADDR, ACC_OFS_CHAN);
  // Hardware vector or software write-one clears the flag
  assign flag_clr = IRQ_ACK || (cs_wr && WDATA[ACC_BIT_IRQ_FLAG]);

  // Assemble control/status read view
  always_comb begin
    cs_val = '0;
    cs_val[ACC_BIT_POWER_OFF] = cur.power_off;
    cs_val[ACC_BIT_BANDGAP] = cur.bandgap;
    cs_val[ACC_BIT_OUT_STATUS] = out_sync;
    cs_val[ACC_BIT_IRQ_FLAG] = cur.irq_flag;
    cs_val[ACC_BIT_IRQ_EN] = cur.irq_en;
    cs_val[ACC_BIT_CAPTURE] = cur.capture;
    cs_val[ACC_BIT_MODE_HI] = cur.mode[1];
    cs_val[ACC_BIT_MODE_LO] = cur.mode[0];
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt = cur;
    // Synchronizer: first stage only feeds the second
    nxt.sync = {cur.sync[ACC_SYNC_STAGES-2:0], CMP_RAW};
    nxt.prev = out_sync;
    // Control/status write; bit 5 is read-only and dropped
    if (cs_wr) begin
      nxt.power_off = WDATA[ACC_BIT_POWER_OFF];
      nxt.bandgap = WDATA[ACC_BIT_BANDGAP];
      nxt.irq_en = WDATA[ACC_BIT_IRQ_EN];
      nxt.capture = WDATA[ACC_BIT_CAPTURE];
      nxt.mode = {WDATA[ACC_BIT_MODE_HI], WDATA[ACC_BIT_MODE_LO]};
    end
    // Special function register keeps only the mux enable
    if (sf_wr) begin
      nxt.mux_en = WDATA[ACC_BIT_MUX_EN];
    end
    // Local copy of the converter enable
    if (cv_wr) begin
      nxt.conv_en = WDATA[ACC_BIT_CONV_EN];
    end
    // Channel field, low three bits
    if (ch_wr) begin
      nxt.chan = WDATA[ACC_CHAN_LSB +: ACC_CHAN_W];
    end
    // Flag clear by ack or write-one; a new event wins
    if (flag_clr) begin
      nxt.irq_flag = 1'b0;
    end
    if (event_hit) begin
      nxt.irq_flag = 1'b1;
    end
    // Read data, valid the cycle after the strobe
    nxt.rdata = '0;
    if (RD) begin
      // Unused bits of each view read zero
      case (ADDR)
        ACC_OFS_CTRL_STATUS: nxt.rdata = cs_val;
        ACC_OFS_SPECIAL: nxt.rdata[ACC_BIT_MUX_EN] = cur.mux_en;
        ACC_OFS_CONV_CTRL: nxt.rdata[ACC_BIT_CONV_EN] = cur.conv_en;
        ACC_OFS_CHAN: nxt.rdata[ACC_CHAN_LSB +: ACC_CHAN_W] = cur.chan;
        default: nxt.rdata = '0; // Unmapped reads zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Whole state in one register; reset clears every field
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RDATA = cur.rdata;
  // Level request, dropped by either enable
  assign IRQ_REQ = cur.irq_flag & cur.irq_en & GLOBAL_IRQ_EN;
  assign CMP_POWER_OFF = cur.power_off;
  assign CMP_POS_BANDGAP = cur.bandgap;
  // Channel index reads zero whenever the dedicated pin is used
  assign CMP_NEG_FROM_CHANNEL = cur.mux_en & ~cur.conv_en;
  assign CMP_NEG_CHANNEL = CMP_NEG_FROM_CHANNEL ? cur.chan
                                                : ACC_CHAN_RESET;
  assign CAPTURE_ROUTE_EN = cur.capture;
  // Raw output goes to capture filter, which does noise/edge work
  assign CAPTURE_SRC = cur.capture & CMP_RAW;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking acc_cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Output status two edges behind the raw result, once out of reset
  chk_sync_latency: assert property (
    $past(RST_N, 2) |-> $past(CMP_RAW, 2) == out_sync)
    else $error("Output status not two cycles behind raw");
  chk_rise_sets: assert property (
    (cur.mode == ACC_MODE_RISE && out_sync && !cur.prev) |=> cur.irq_flag)
    else $error("Rising edge did not set flag");
  chk_fall_sets: assert property (
    (cur.mode == ACC_MODE_FALL && !out_sync && cur.prev) |=> cur.irq_flag)
    else $error("Falling edge did not set flag");
  chk_reserved_quiet: assert property (
    (cur.mode == ACC_MODE_RESERVED && !cur.irq_flag && !cs_wr)
      |=> !cur.irq_flag)
    else $error("Reserved mode set flag");
  chk_ack_clears: assert property (
    (IRQ_ACK && !event_hit) |=> !cur.irq_flag)
    else $error("Acknowledge did not clear flag");
  chk_irq_gate: assert property (
    (cs_wr && !WDATA[ACC_BIT_IRQ_EN]) |=> !IRQ_REQ)
    else $error("Request still up after enable written zero");
  chk_capture_off: assert property (
    !cur.capture |-> !CAPTURE_SRC)
    else $error("Capture source active while unrouted");
  chk_neg_select: assert property (
    (cur.conv_en || !cur.mux_en) |-> !CMP_NEG_FROM_CHANNEL)
    else $error("Channel used while converter on or mux off");
  chk_power_write: assert property (
    cs_wr |=> CMP_POWER_OFF == $past(WDATA[ACC_BIT_POWER_OFF]))
    else $error("Power-off bit not taken from write");

  // Register fields follow the write that lands
  chk_bandgap_write: assert property (
    cs_wr |=> CMP_POS_BANDGAP == $past(WDATA[ACC_BIT_BANDGAP]))
    else $error("Bandgap bit not taken from write");
  chk_route_write: assert property (
    cs_wr |=> CAPTURE_ROUTE_EN == $past(WDATA[ACC_BIT_CAPTURE]))
    else $error("Routing bit not taken from write");
  chk_mode_write: assert property (
    cs_wr |=> cur.mode == $past({WDATA[ACC_BIT_MODE_HI],
                                 WDATA[ACC_BIT_MODE_LO]}))
    else $error("Mode bits not taken from write");

  // Flag set, hold and clear
  chk_toggle_sets: assert property (
    (cur.mode == ACC_MODE_TOGGLE && out_sync != cur.prev) |=> cur.irq_flag)
    else $error("Toggle did not set flag");
  chk_rise_quiet: assert property (
    (cur.mode == ACC_MODE_RISE && !cur.irq_flag && !(out_sync && !cur.prev))
      |=> !cur.irq_flag)
    else $error("Flag set without rising edge");
  chk_fall_quiet: assert property (
    (cur.mode == ACC_MODE_FALL && !cur.irq_flag && !(cur.prev && !out_sync))
      |=> !cur.irq_flag)
    else $error("Flag set without falling edge");
  chk_write_clears: assert property (
    (cs_wr && WDATA[ACC_BIT_IRQ_FLAG] && !event_hit) |=> !cur.irq_flag)
    else $error("Write of one did not clear flag");
  chk_flag_sticky: assert property (
    (cur.irq_flag && !flag_clr) |=> cur.irq_flag)
    else $error("Flag dropped without a clear");
  chk_prev_follows: assert property (
    cur.prev == $past(out_sync))
    else $error("Previous value not one cycle behind");

  // Negative input routing
  chk_chan_route: assert property (
    (cur.mux_en && !cur.conv_en)
      |-> (CMP_NEG_FROM_CHANNEL && CMP_NEG_CHANNEL == cur.chan))
    else $error("Channel not routed to negative input");

  // Read views, one cycle after the strobe
  chk_status_read: assert property (
    (RD && ADDR == ACC_OFS_CTRL_STATUS)
      |=> RDATA[ACC_BIT_OUT_STATUS] == $past(out_sync))
    else $error("Output status bit not read back");
  chk_mux_read: assert property (
    (RD && ADDR == ACC_OFS_SPECIAL)
      |=> RDATA[ACC_BIT_MUX_EN] == $past(cur.mux_en))
    else $error("Mux enable not read back");
  chk_chan_read: assert property (
    (RD && ADDR == ACC_OFS_CHAN)
      |=> RDATA[ACC_CHAN_LSB +: ACC_CHAN_W] == $past(cur.chan))
    else $error("Channel field not read back");

  // ----------------------------------------------------------------
  // Cover properties
  // ----------------------------------------------------------------
  cov_toggle_irq: cover property (
    cur.mode == ACC_MODE_TOGGLE && event_hit);
  cov_irq_req: cover property (IRQ_REQ ##1 IRQ_ACK);
  cov_chan_route: cover property (CMP_NEG_FROM_CHANNEL);
  cov_set_clear: cover property (event_hit && IRQ_ACK);
  cov_fall_irq: cover property (cur.mode == ACC_MODE_FALL && event_hit);

endmodule : acc_top

`default_nettype wire

// ===== verification/acc_partner.sv
/*
  Far side model: comparator result from pin levels, and a capture
  front end that filters the routed result and counts rising edges.
  Assumes digital pin levels and a bandgap level that reads high.
*/
`timescale 1ns/10ps
`default_nettype none
module acc_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Controls from the block
  input wire logic power_off,
  input wire logic pos_bandgap,
  input wire logic neg_from_channel,
  input wire logic [2:0] neg_channel,
  input wire logic capture_src,
  // Pin levels
  input wire logic pos_pin,
  input wire logic neg_pin,
  input wire logic [7:0] channel_pins,
  // Raw result and capture count
  output logic cmp_raw,
  output logic [7:0] capture_count
);
  logic [1:0] filt; // Capture filter, bit 0 newest
  // Comparator: high when positive side above negative, low when off
  assign cmp_raw = ~power_off & (pos_bandgap | pos_pin) &
    ~(neg_from_channel ? channel_pins[neg_channel] : neg_pin);
  // Filter the routed result, then count its rising edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt <= 2'h0;
      capture_count <= 8'h0;
    end else begin
      filt <= {filt[0], capture_src};
      if (filt == 2'b01) capture_count <= capture_count + 8'h1;
    end
  end
endmodule : acc_partner
`default_nettype wire

// ===== verification/tb_top.sv
/*
  Self-checking bench for the comparator control block.
  Assumes the partner model drives the raw comparator result.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import acc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, gie = 1'b0;
  logic ack = 1'b0, irq, raw, off, bg, nfc, cre, csrc, pos = 1'b0;
  logic neg = 1'b0, sel, nv, ev, ien;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h0, rdata, chan = 8'h0, cnt, r, d, m, c, ch;
  logic [2:0] nch;
  logic [31:0] seed = 32'hb0aa5879, t;
  int num_errors = 0, compares = 0;
  always #5 clk = ~clk;
  acc_top i_dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .GLOBAL_IRQ_EN(gie), .IRQ_ACK(ack),
    .IRQ_REQ(irq), .CMP_RAW(raw), .CMP_POWER_OFF(off),
    .CMP_POS_BANDGAP(bg), .CMP_NEG_FROM_CHANNEL(nfc),
    .CMP_NEG_CHANNEL(nch), .CAPTURE_ROUTE_EN(cre), .CAPTURE_SRC(csrc));
  acc_partner i_far (.clk(clk), .rst_n(rst_n), .power_off(off),
    .pos_bandgap(bg), .neg_from_channel(nfc), .neg_channel(nch),
    .capture_src(csrc), .pos_pin(pos), .neg_pin(neg),
    .channel_pins(chan), .cmp_raw(raw), .capture_count(cnt));
  // Register write, ends one edge after it lands
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0; @(posedge clk);
  endtask : wr_reg
  // Register read, data taken in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0; #1 v = rdata; @(posedge clk);
  endtask : rd_reg
  // Compare and count
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Whether a mode fires on a rising or falling result
  function automatic logic fires(input logic [1:0] md, input logic up);
    case (md)
      ACC_MODE_TOGGLE: return 1'b1;
      ACC_MODE_FALL: return ~up;
      ACC_MODE_RISE: return up;
      default: return 1'b0;
    endcase
  endfunction : fires
  // Verdict and end of run
  task automatic final_report;
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report;
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 4; a++) begin
      rd_reg(a[3:0], r); chk("reset_value", 8'h00, r);
    end
    rd_reg(4'hf, r); chk("unmapped", 8'h00, r);
    // Every mode, rising then falling result
    for (int i = 0; i < 8; i++) begin
      wr_reg(ACC_OFS_CTRL_STATUS, {6'h0, i[2:1]});
      wr_reg(ACC_OFS_CTRL_STATUS, {6'h4, i[2:1]});
      pos <= ~i[0];
      repeat (4) @(posedge clk);
      rd_reg(ACC_OFS_CTRL_STATUS, r);
      chk("mode_flag", {2'h0, ~i[0], fires(i[2:1], ~i[0]), 2'h0, i[2:1]},
          r);
    end
    // Request gating and clear by the vector
    for (int k = 0; k < 4; k++) begin
      ien = k[1];
      wr_reg(ACC_OFS_CTRL_STATUS, 8'h10);
      wr_reg(ACC_OFS_CTRL_STATUS, {4'h0, ien, 3'h0});
      gie <= k[0]; pos <= ~pos;
      repeat (4) @(posedge clk);
      chk("irq_req", {7'h0, k[0] & ien}, {7'h0, irq});
      ack <= 1'b1; @(posedge clk); ack <= 1'b0; @(posedge clk);
      chk("irq_after_ack", 8'h0, {7'h0, irq});
      rd_reg(ACC_OFS_CTRL_STATUS, r); chk("ack_flag", 8'h0, r & 8'h10);
    end
    // Random controls, input selection and routing
    for (int i = 0; i < 16; i++) begin
      t = $random(seed); d = t[7:0]; m = t[15:8]; c = t[23:16];
      ch = t[31:24]; d[4] = 1'b0; d[3] = 1'b0;
      t = $random(seed); chan <= t[7:0]; neg <= t[8];
      wr_reg(ACC_OFS_SPECIAL, m); wr_reg(ACC_OFS_CONV_CTRL, c);
      wr_reg(ACC_OFS_CHAN, ch); wr_reg(ACC_OFS_CTRL_STATUS, d);
      sel = m[3] & ~c[7];
      nv = sel ? chan[ch[2:0]] : neg;
      ev = ~d[7] & (d[6] | pos) & ~nv;
      repeat (2) @(posedge clk);
      chk("neg_sel", {7'h0, sel}, {7'h0, nfc});
      chk("neg_chan", {5'h0, sel ? ch[2:0] : 3'h0}, {5'h0, nch});
      chk("ctrl_out", {5'h0, d[7:6], d[2]}, {5'h0, off, bg, cre});
      chk("capture_src", {7'h0, ev & d[2]}, {7'h0, csrc});
      rd_reg(ACC_OFS_CTRL_STATUS, r);
      chk("status", {d[7:6], ev, 5'h0} | (d & 8'h0f), r & 8'hef);
      rd_reg(ACC_OFS_SPECIAL, r); chk("mux_en", m & 8'h08, r);
    end
    // Routed result reaches the capture filter
    wr_reg(ACC_OFS_SPECIAL, 8'h00); neg <= 1'b0; pos <= 1'b0;
    wr_reg(ACC_OFS_CTRL_STATUS, 8'h04);
    repeat (4) @(posedge clk);
    r = cnt;
    for (int i = 0; i < 4; i++) begin
      pos <= ~i[0]; repeat (4) @(posedge clk);
    end
    chk("capture_edges", r + 8'h2, cnt);
    // Reset in mid-run clears every register and the request
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset_rdata", 8'h00, rdata);
    chk("reset_irq", 8'h00, {7'h0, irq});
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 4; a++) begin
      rd_reg(a[3:0], r);
      chk("mid_reset", 8'h00, r);
    end
    final_report;
  end
endmodule : tb_top
`default_nettype wire
